// [sccp_pkg.sv]
// Package for the smart card serial control port: bit positions,
// register map of the Avalon slave, timing figures and carrier structs.
// Assumes a 125 MHz system clock.
`default_nettype none
package sccp_pkg;
   localparam int CLK_MHZ = 125;
   localparam int BYTE_BITS = 8;
   // Status word and command bit positions
   localparam int CARD_PRESENT_BIT = 7;
   localparam int FAULT_FLAG_BIT = 4;
   localparam int SUPPLY_SELECT_BIT0 = 0;
   localparam int SUPPLY_SELECT_BIT1 = 1;
   // Fault to deactivation delay
   localparam int FAULT_DELAY_US = 30;
   localparam int FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ;
   // Register byte addresses and reset values
   localparam logic [3:0] ADDR_COMMAND = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   // Interrupt bit positions
   localparam int IRQ_COMMIT = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_CARD = 2;
   localparam int IRQ_BITS = 3;

   typedef struct packed {
      logic sclk;
      logic din;
      logic load_strobe_n;
   } sccp_link_in_type;

   typedef struct packed {
      logic deactivating;
      logic shutdown;
      logic [1:0] supply_class;
   } sccp_card_ctl_type;
endpackage
`default_nettype wire

// [sccp_sync.sv]
// Two flip-flop synchroniser for a group of single-bit inputs.
// Assumes inputs are asynchronous to clock; reset value is all zero.
`default_nettype none
module sccp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// [sccp_top.sv]
// Serial control and status port of a smart card interface, device side.
// Assumes the shift clock, data input and load strobe come from a master
// in another clock domain; card-side sense inputs are asynchronous too.
//
// Implementation choices: the address map and the Avalon-MM register port.
`default_nettype none
module sccp_top #(
   parameter int FAULT_DELAY = sccp_pkg::FAULT_DELAY_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Serial link pins
   input wire logic sclk,
   input wire logic din,
   input wire logic load_strobe_n,
   output logic dout,
   // Card side inputs
   input wire logic logic_supply,
   input wire logic card_sense,
   input wire logic fault_sense,
   input wire logic status_aux_6,
   input wire logic status_aux_5,
   input wire logic [3:0] status_low,
   // Card side outputs
   output sccp_pkg::sccp_card_ctl_type card_ctl,
   output logic [7:0] command,
   // Open-drain fault pin
   output logic fault_o,
   output logic fault_oe,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   localparam int NSYNC = 12;
   logic [NSYNC-1:0] sync_raw;
   logic [NSYNC-1:0] sync_s;
   sccp_pkg::sccp_link_in_type link_s;
   logic supply_s;
   logic card_s;
   logic fault_s;
   logic aux6_s;
   logic aux5_s;
   logic [3:0] low_s;

   assign sync_raw = {sclk, din, load_strobe_n, logic_supply, card_sense,
                      fault_sense, status_aux_6, status_aux_5, status_low};

   sccp_sync #(
      .WIDTH(NSYNC)
   ) u_sync (
      .clock(clock),
      .arst_n(arst_n),
      .async_in(sync_raw),
      .sync_out(sync_s)
   );

   // Link pins sit in the top three bits, in struct order
   assign link_s = sync_s[11:9];
   assign supply_s = sync_s[8];
   assign card_s = sync_s[7];
   assign fault_s = sync_s[6];
   assign aux6_s = sync_s[5];
   assign aux5_s = sync_s[4];
   assign low_s = sync_s[3:0];

   // ==========================================================
   // Edge detection on the link
   // ==========================================================
   sccp_pkg::sccp_link_in_type link_prev_q;
   logic [1:0] prime_q;
   logic primed;
   logic sclk_rise;
   logic sclk_fall;
   logic ld_fall;
   logic ld_rise;

   function automatic logic went_high(input logic now_v, input logic was_v);
      return now_v && !was_v;
   endfunction

   function automatic logic went_low(input logic now_v, input logic was_v);
      return !now_v && was_v;
   endfunction

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         link_prev_q <= '{sclk: 1'b1, din: 1'b0, load_strobe_n: 1'b1};
      end else begin
         link_prev_q <= link_s;
      end
   end

   // Synchronisers leave reset at zero, not at the pins' idle levels, so
   // edges are ignored until both stages and the history flop hold real
   // samples; otherwise a false strobe fall would commit a stale command
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prime_q <= 2'b00;
      end else if (prime_q != 2'b11) begin
         prime_q <= prime_q + 2'b01;
      end
   end

   assign primed = (prime_q == 2'b11);

   // Mode 1/0: din is captured on the leading fall, dout moves on the rise
   assign sclk_fall = primed && went_low(link_s.sclk, link_prev_q.sclk);
   assign sclk_rise = primed && went_high(link_s.sclk, link_prev_q.sclk);
   assign ld_fall = primed && went_low(link_s.load_strobe_n, link_prev_q.load_strobe_n);
   assign ld_rise = primed && went_high(link_s.load_strobe_n, link_prev_q.load_strobe_n);

   // ==========================================================
   // Status word assembly
   // ==========================================================
   logic fault_flag_q;
   logic [7:0] status_word;

   assign status_word = {card_s, aux6_s, aux5_s, fault_flag_q, low_s};

   // ==========================================================
   // Shift register
   // ==========================================================
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic shift_en;
   logic din_hold_q;

   // Shifting only while the strobe is high; the master never strobes
   // mid-chain, so each device keeps exactly one byte.
   assign shift_en = sclk_rise && link_s.load_strobe_n;
   assign shift_d = ld_rise ? status_word :
                    shift_en ? {shift_q[6:0], din_hold_q} : shift_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= 8'h00;
      end else begin
         shift_q <= shift_d;
      end
   end

   // Taken half a shift period before it enters, so a master that moves
   // din on the rising edge never races the shift
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         din_hold_q <= 1'b0;
      end else if (sclk_fall && link_s.load_strobe_n) begin
         din_hold_q <= link_s.din;
      end
   end

   // Transparent while strobe low: live card detect for the master
   assign dout = link_s.load_strobe_n ? shift_q[7] : card_s;

   // ==========================================================
   // Command register
   // ==========================================================
   logic [7:0] command_q;
   logic [7:0] command_d;
   logic [7:0] command_live;

   assign command_d = ld_fall ? shift_q : command_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         command_q <= sccp_pkg::COMMAND_RESET;
      end else begin
         command_q <= command_d;
      end
   end

   // Bypass so the new command drives outputs in the fall cycle itself
   assign command_live = ld_fall ? shift_q : command_q;
   assign command = command_live;

   // ==========================================================
   // Supply control and deactivation
   // ==========================================================
   logic [1:0] supply_class;
   logic supply_off;
   logic fault_pending_q;
   logic [$clog2(FAULT_DELAY+1)-1:0] fault_cnt_q;
   logic fault_deact_q;
   logic fault_timeout;
   logic power_down_commit;

   // Any class, including a direct change, goes straight through
   assign supply_class = {command_live[sccp_pkg::SUPPLY_SELECT_BIT1],
                          command_live[sccp_pkg::SUPPLY_SELECT_BIT0]};
   assign supply_off = (supply_class == 2'b00);
   assign fault_timeout = fault_pending_q &&
      (fault_cnt_q == ($clog2(FAULT_DELAY+1))'(FAULT_DELAY - 1));

   // Only a committed power-down clears a latched fault
   assign power_down_commit = ld_fall && supply_off;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fault_pending_q <= 1'b0;
         fault_cnt_q <= '0;
      end else if (fault_s && !fault_pending_q && !fault_deact_q) begin
         fault_pending_q <= 1'b1;
         fault_cnt_q <= '0;
      end else if (fault_timeout) begin
         fault_pending_q <= 1'b0;
         fault_cnt_q <= '0;
      end else if (fault_pending_q) begin
         fault_cnt_q <= fault_cnt_q + 1'b1;
      end
   end

   // Fault flag and deactivation latch until a power-down command
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fault_flag_q <= 1'b0;
         fault_deact_q <= 1'b0;
      end else begin
         if (fault_s) begin
            fault_flag_q <= 1'b1;
         end else if (power_down_commit) begin
            fault_flag_q <= 1'b0;
         end
         if (fault_timeout) begin
            fault_deact_q <= 1'b1;
         end else if (power_down_commit) begin
            fault_deact_q <= 1'b0;
         end
      end
   end

   assign card_ctl.shutdown = !supply_s;
   assign card_ctl.deactivating = !supply_s || supply_off || fault_deact_q;
   assign card_ctl.supply_class = (!supply_s || fault_deact_q) ? 2'b00 : supply_class;

   // Open-drain: enabled (pulling low) exactly while the flag is set
   assign fault_o = 1'b0;
   assign fault_oe = fault_flag_q;

   // ==========================================================
   // Interrupt status and mask
   // ==========================================================
   logic [2:0] irq_status_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_event;
   logic card_prev_q;
   logic fault_prev_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         card_prev_q <= 1'b0;
         fault_prev_q <= 1'b0;
      end else begin
         card_prev_q <= card_s;
         fault_prev_q <= fault_flag_q;
      end
   end

   assign irq_event[sccp_pkg::IRQ_COMMIT] = ld_fall;
   assign irq_event[sccp_pkg::IRQ_FAULT] = fault_flag_q && !fault_prev_q;
   assign irq_event[sccp_pkg::IRQ_CARD] = primed && (card_s != card_prev_q);

   // ==========================================================
   // Avalon-MM slave
   // ==========================================================
   logic sel_command;
   logic sel_status;
   logic sel_irq_status;
   logic sel_irq_mask;
   logic rd_ack;
   logic [31:0] rd_mux;
   logic [31:0] readdata_q;
   logic rd_done_q;

   assign sel_command = avs_address == sccp_pkg::ADDR_COMMAND;
   assign sel_status = avs_address == sccp_pkg::ADDR_STATUS;
   assign sel_irq_status = avs_address == sccp_pkg::ADDR_IRQ_STATUS;
   assign sel_irq_mask = avs_address == sccp_pkg::ADDR_IRQ_MASK;

   // Reads take one wait cycle so read data come from a flip-flop
   assign avs_waitrequest = avs_read && !rd_done_q;
   assign rd_ack = avs_read && !rd_done_q;

   assign rd_mux = sel_command ? {24'h00_0000, command_q} :
                   sel_status ? {24'h00_0000, status_word} :
                   sel_irq_status ? {29'h000_0000, irq_status_q} :
                   sel_irq_mask ? {29'h000_0000, irq_mask_q} :
                   32'h0000_0000;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         readdata_q <= 32'h0000_0000;
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= rd_ack;
         if (rd_ack) begin
            readdata_q <= rd_mux;
         end
      end
   end

   assign avs_readdata = readdata_q;

   // Set beats the read-clear so no event is lost
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_status_q <= 3'h0;
         irq_mask_q <= sccp_pkg::IRQ_MASK_RESET;
      end else begin
         irq_status_q <= (rd_ack && sel_irq_status ? 3'h0 : irq_status_q) | irq_event;
         if (avs_write && sel_irq_mask) begin
            irq_mask_q <= avs_writedata[2:0];
         end
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);
endmodule
`default_nettype wire

// [sccp_assertions.sv]
// Checker for the smart card serial control port, bound to sccp_top.
// Assumes the top module's ports only; one clock domain.
`default_nettype none
module sccp_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Link
   input wire logic sclk,
   input wire logic load_strobe_n,
   input wire logic dout,
   // Card side
   input wire logic logic_supply,
   input wire logic card_sense,
   input wire logic fault_sense,
   input wire sccp_pkg::sccp_card_ctl_type card_ctl,
   input wire logic [7:0] command,
   input wire logic fault_o,
   input wire logic fault_oe,
   // Avalon
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ==========
   // Read and write handshake
   sequence rd_first;
      $rose(avs_read) ##0 avs_waitrequest;
   endsequence
   read_wait_a: assert property (rd_first |=> !avs_waitrequest)
      else $error("read not answered in second cycle");
   write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest
      && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   // ==========
   // Link and card side
   commit_edge_a: assert property ($changed(command) |-> !load_strobe_n)
      else $error("command changed with strobe high");
   transparent_a: assert property ((!load_strobe_n && $stable(card_sense))[*6]
      |-> dout == card_sense) else $error("dout not following card sense");
   shift_hold_a: assert property ((load_strobe_n && $stable(sclk)
      && $stable(load_strobe_n))[*8] |-> $stable(dout)) else $error("dout moved unclocked");
   fault_pin_a: assert property ($rose(fault_sense) |-> ##[1:6] fault_oe)
      else $error("fault pin not pulled");
   fault_low_a: assert property (fault_o == 1'b0)
      else $error("fault pin driven high");
   shutdown_a: assert property ((!logic_supply)[*4] |-> card_ctl.shutdown)
      else $error("no shutdown without logic supply");
endmodule
bind sccp_top sccp_checker u_chk (.clock(clock), .arst_n(arst_n), .sclk(sclk),
   .load_strobe_n(load_strobe_n), .dout(dout), .logic_supply(logic_supply),
   .card_sense(card_sense), .fault_sense(fault_sense), .card_ctl(card_ctl),
   .command(command), .fault_o(fault_o), .fault_oe(fault_oe), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// [sccp_master_select_setting_model.sv]
// Master side of the serial link: shift clock idles high, MSB first.
// Assumes the bench clock; half shift period is four clocks.
`default_nettype none
module sccp_master_select_setting_model (
   // Clock
   input wire logic clock,
   // Link
   input wire logic dout,
   output logic sclk,
   output logic din,
   output logic load_strobe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b1;
      din = 1'b0;
      load_strobe_n = 1'b1;
   end
   // Phase 0: first bit stands before the leading fall, the rest move on
   // each trailing rise; dout is read at the fall
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      din <= tx[7];
      for (int i = 7; i >= 0; i--) begin
         repeat (4) @(posedge clock);
         sclk <= 1'b0;
         rx[i] = dout;
         repeat (4) @(posedge clock);
         sclk <= 1'b1;
         if (i > 0) begin
            din <= tx[i-1];
         end
      end
   endtask
   // Strobe moves only between whole chain transfers
   task automatic set_strobe(input logic v);
      @(posedge clock) load_strobe_n <= v;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Bench for sccp_top: Avalon tasks, link master model, sense inputs.
// Assumes the checker is bound from its own file.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic logic_supply = 1'b1, card_sense = 1'b1, fault_sense = 1'b0;
   logic aux6 = 1'b0, aux5 = 1'b1;
   logic [3:0] status_low = 4'h3;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   logic sclk, din, load_strobe_n, dout, fault_o, fault_oe, avs_waitrequest, irq;
   logic [7:0] command, rx;
   sccp_pkg::sccp_card_ctl_type card_ctl;
   int mismatches = 0, total_checks = 0, cycles = 0;
   always #4 clock = ~clock;
   sccp_top #(.FAULT_DELAY(20)) dut (.clock(clock), .arst_n(arst_n), .sclk(sclk), .din(din),
      .load_strobe_n(load_strobe_n), .dout(dout), .logic_supply(logic_supply),
      .card_sense(card_sense), .fault_sense(fault_sense), .status_aux_6(aux6),
      .status_aux_5(aux5), .status_low(status_low), .card_ctl(card_ctl), .command(command),
      .fault_o(fault_o), .fault_oe(fault_oe), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
   sccp_master_select_setting_model m (.clock(clock), .dout(dout), .sclk(sclk), .din(din),
      .load_strobe_n(load_strobe_n));
   // ==========
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock) avs_read <= 1'b1;
      avs_address <= a;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock) avs_write <= 1'b1;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done;
      end
   end
   // ==========
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      av_rd(sccp_pkg::ADDR_COMMAND, rd);
      check(rd, 32'h0000_0000);
      av_rd(sccp_pkg::ADDR_IRQ_MASK, rd);
      check(rd, 32'h0000_0000);
      av_rd(4'h2, rd);
      check(rd, 32'h0000_0000);
      av_wr(sccp_pkg::ADDR_COMMAND, 32'h0000_00FF);
      m.xfer(8'h3C, rx);
      m.xfer(8'hC1, rx);
      check(rx, 8'h3C);
      m.set_strobe(1'b0);
      check(command, 8'hC1);
      check(card_ctl.supply_class, 2'b01);
      check(irq, 1'b0);
      av_wr(sccp_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      av_rd(sccp_pkg::ADDR_IRQ_MASK, rd);
      check(rd, 32'h0000_0007);
      check(irq, 1'b1);
      av_rd(sccp_pkg::ADDR_IRQ_STATUS, rd);
      check(rd, 32'h0000_0001);
      check(irq, 1'b0);
      // Strobe held low: dout tracks the card sense live
      @(posedge clock) card_sense <= 1'b0;
      repeat (6) @(posedge clock);
      check(dout, 1'b0);
      @(posedge clock) card_sense <= 1'b1;
      repeat (6) @(posedge clock);
      check(dout, 1'b1);
      m.set_strobe(1'b1);
      m.xfer(8'h02, rx);
      check(rx, 8'hA3);
      m.set_strobe(1'b0);
      check(card_ctl.supply_class, 2'b10);
      m.set_strobe(1'b1);
      av_rd(sccp_pkg::ADDR_IRQ_STATUS, rd);
      check(rd, 32'h0000_0005);
      @(posedge clock) fault_sense <= 1'b1;
      repeat (6) @(posedge clock);
      check(fault_oe, 1'b1);
      repeat (30) @(posedge clock);
      check(card_ctl.supply_class, 2'b00);
      av_rd(sccp_pkg::ADDR_STATUS, rd);
      check(rd, 32'h0000_00B3);
      av_rd(sccp_pkg::ADDR_IRQ_STATUS, rd);
      check(rd, 32'h0000_0002);
      @(posedge clock) fault_sense <= 1'b0;
      m.xfer(8'h00, rx);
      m.set_strobe(1'b0);
      check(fault_oe, 1'b0);
      m.set_strobe(1'b1);
      // New class only after the power-down commit
      m.xfer(8'h03, rx);
      check(rx, 8'hA3);
      m.set_strobe(1'b0);
      check(card_ctl.supply_class, 2'b11);
      m.set_strobe(1'b1);
      @(posedge clock) logic_supply <= 1'b0;
      repeat (6) @(posedge clock);
      check(card_ctl.shutdown, 1'b1);
      @(posedge clock) logic_supply <= 1'b1;
      repeat (6) @(posedge clock);
      check(card_ctl.shutdown, 1'b0);
      @(posedge clock) aux6 <= 1'b1;
      aux5 <= 1'b0;
      status_low <= 4'hC;
      repeat (4) @(posedge clock);
      av_rd(sccp_pkg::ADDR_STATUS, rd);
      check(rd, 32'h0000_00CC);
      test_done;
   end
endmodule
`default_nettype wire
